// *** dv/uart_receiver_flow_sleep_tb.sv ***
// self-checking testbench for the uart receiver block
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module uart_receiver_flow_sleep_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic                      clk;
  logic                      rst;
  logic                      rx_enable_flag;
  urxfs_pkg::urxfs_cfg_type   cfg;
  urxfs_pkg::urxfs_flow_type  flow;
  logic                      int_src_tick;
  logic                      buf_lo_read;
  logic [8:0]                rx_buffer;
  urxfs_pkg::urxfs_flags_type flags;
  logic                      rx_irq;
  logic                      clear_to_send_in;
  logic                      rxd;
  logic                      flow_pin_in;
  logic                      flow_pin_out;
  logic                      flow_pin_oe;
  logic                      serial_clock_pin;
  logic                      serial_clock_oe;
  int                        n_errors;
  int                        samples_checked;
  int                        irq_cnt;

  urxfs_rx u_dut (
    .clk              (clk),
    .rst              (rst),
    .rx_enable_flag   (rx_enable_flag),
    .cfg              (cfg),
    .flow             (flow),
    .int_src_tick     (int_src_tick),
    .buf_lo_read      (buf_lo_read),
    .rx_buffer        (rx_buffer),
    .flags            (flags),
    .rx_irq           (rx_irq),
    .clear_to_send_in (clear_to_send_in),
    .rxd              (rxd),
    .flow_pin_in      (flow_pin_in),
    .flow_pin_out     (flow_pin_out),
    .flow_pin_oe      (flow_pin_oe),
    .serial_clock_pin (serial_clock_pin),
    .serial_clock_oe  (serial_clock_oe)
  );

  // 16x tick every 4 clocks, so one bit lasts 64 clocks
  urxfs_tx_model #(.BIT_CLKS(64)) u_tx (
    .clk       (clk),
    .rts_level (flow_pin_out),
    .txd       (rxd)
  );

  // ==========================================================
  // clock, source tick, interrupt counter
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk) int_src_tick <= ~int_src_tick;

  always @(posedge clk) if (rx_irq === 1'b1) irq_cnt <= irq_cnt + 1;

  // ==========================================================
  // tasks
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rd();
    buf_lo_read = 1'b1;
    step(1);
    buf_lo_read = 1'b0;
    step(2);
  endtask

  task automatic frm(input logic [8:0] d, input int nb, input logic fp,
                     input logic bs, input logic ign);
    u_tx.send(d, nb, cfg.parity_en, cfg.parity_odd, fp,
              cfg.two_stop ? 2 : 1, bs, ign, 3);
    step(4);
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // watchdog, about five times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // ==========================================================
  // tests
  initial begin
    n_errors = 0;
    samples_checked = 0;
    irq_cnt = 0;
    rst = 1'b1;
    rx_enable_flag = 1'b0;
    cfg = '0;
    cfg.data_len = urxfs_pkg::LEN_8;
    cfg.rts_sel = 1'b1;
    cfg.brg_n = 8'h01;
    flow = '0;
    flow.func_sel = 1'b1;
    int_src_tick = 1'b0;
    buf_lo_read = 1'b0;
    flow_pin_in = 1'b1;
    serial_clock_pin = 1'b1;
    step(5);
    rst = 1'b0;
    step(3);
    `CHK(flags, 5'h00)
    `CHK(rx_buffer, 9'h000)
    `CHK(flow_pin_out, 1'b1)
    `CHK(flow_pin_oe, 1'b1)
    // disabled receiver ignores a frame, ready stays high
    frm(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
    `CHK(rx_buffer, 9'h000)
    `CHK(flow_pin_out, 1'b1)
    rx_enable_flag = 1'b1;
    step(4);
    `CHK(flow_pin_out, 1'b0)
    // plain frame; ready rises once the start bit is seen
    fork
      frm(9'h0a5, 8, 1'b0, 1'b0, 1'b0);
      begin
        step(30);
        `CHK(flow_pin_out, 1'b1)
      end
    join
    `CHK(rx_buffer, 9'h0a5)
    `CHK(flags, 5'h10)
    `CHK(irq_cnt, 1)
    `CHK(flow_pin_out, 1'b1)
    rd();
    `CHK(flow_pin_out, 1'b0)
    `CHK(flags, 5'h00)
    // back to back without a read gives an overrun
    frm(9'h03c, 8, 1'b0, 1'b0, 1'b0);
    frm(9'h0c3, 8, 1'b0, 1'b0, 1'b1);
    `CHK(rx_buffer, 9'h0c3)
    `CHK(flags, 5'h19)
    `CHK(irq_cnt, 3)
    rd();
    `CHK(flags, 5'h09)
    rx_enable_flag = 1'b0;
    step(3);
    `CHK(flags, 5'h00)
    rx_enable_flag = 1'b1;
    step(4);
    // even parity, wrong parity bit, two stops
    cfg.parity_en = 1'b1;
    cfg.two_stop = 1'b1;
    frm(9'h017, 8, 1'b1, 1'b0, 1'b0);
    `CHK(flags, 5'h13)
    rd();
    `CHK(flags, 5'h00)
    // odd parity, correct, then a low stop bit
    cfg.parity_odd = 1'b1;
    frm(9'h017, 8, 1'b0, 1'b0, 1'b0);
    `CHK(flags, 5'h10)
    rd();
    frm(9'h081, 8, 1'b0, 1'b1, 1'b0);
    `CHK(flags, 5'h15)
    rx_enable_flag = 1'b0;
    step(3);
    `CHK(flags, 5'h10)
    rx_enable_flag = 1'b1;
    rd();
    // errors-only interrupt mode
    cfg.int_mode = 1'b1;
    frm(9'h044, 8, 1'b0, 1'b0, 1'b0);
    `CHK(irq_cnt, 6)
    rd();
    frm(9'h044, 8, 1'b1, 1'b0, 1'b0);
    `CHK(irq_cnt, 7)
    rd();
    cfg = '0;
    cfg.rts_sel = 1'b1;
    cfg.brg_n = 8'h01;
    // short low pulse on the line is not a start bit
    u_tx.glitch(8);
    step(100);
    `CHK(flags, 5'h00)
    `CHK(rx_buffer, 9'h044)
    // sleep: data frame dropped, address frame received
    cfg.sleep_sel = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cfg.data_len = 2'(i);
      frm(9'h0aa >> (2 - i), 7 + i, 1'b0, 1'b0, 1'b1);
      `CHK(flags, 5'h00)
      frm(9'h1a3 >> (2 - i), 7 + i, 1'b0, 1'b0, 1'b1);
      `CHK(rx_buffer, 9'h1a3 >> (2 - i))
      `CHK(flags, 5'h10)
      rd();
    end
    `CHK(irq_cnt, 10)
    // pin role table
    flow = '0;
    flow_pin_in = 1'b0;
    step(5);
    `CHK(clear_to_send_in, 1'b0)
    `CHK(flow_pin_oe, 1'b0)
    flow_pin_in = 1'b1;
    step(5);
    `CHK(clear_to_send_in, 1'b1)
    flow.separate = 1'b1;
    serial_clock_pin = 1'b0;
    step(5);
    `CHK(clear_to_send_in, 1'b0)
    `CHK(flow_pin_oe, 1'b1)
    `CHK(serial_clock_oe, 1'b0)
    // external clock asked for, but separated pins force the internal one
    cfg.sleep_sel = 1'b0;
    cfg.ext_clk_sel = 1'b1;
    frm(9'h05a, 9, 1'b0, 1'b0, 1'b1);
    `CHK(rx_buffer, 9'h05a)
    `CHK(flags, 5'h10)
    flow.flow_disable = 1'b1;
    step(5);
    `CHK(flow_pin_oe, 1'b0)
    final_report();
  end

endmodule // uart_receiver_flow_sleep_tb

// *** dv/urxfs_tx_model.sv ***
// remote asynchronous transmitter model driving the receiver's serial input
module urxfs_tx_model #(
  parameter int BIT_CLKS = 64
) (
  // clock
  input  wire logic clk,
  // flow control seen from the receiver
  input  wire logic rts_level,
  // serial line
  output logic      txd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // frame sender
  initial txd = 1'b1;

  // waits for the receiver's ready level unless told to ignore it,
  // which, like a flipped parity bit or a low first stop bit, is a misbehaviour a scenario may command
  task automatic send(input logic [8:0] d, input int nb, input logic pe,
                      input logic po, input logic flip_par, input int ns,
                      input logic bad_stop, input logic ignore_rts,
                      input int gap);
    logic par;
    int   k;
    par = po;
    k = 0;
    while (!ignore_rts && rts_level !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    repeat (gap) @(negedge clk);
    txd = 1'b0;
    repeat (BIT_CLKS) @(negedge clk);
    // lsb first, top bit marks an address frame in sleep use
    for (int i = 0; i < nb; i++) begin
      txd = d[i];
      par = par ^ d[i];
      repeat (BIT_CLKS) @(negedge clk);
    end
    if (pe) begin
      txd = par ^ flip_par;
      repeat (BIT_CLKS) @(negedge clk);
    end
    for (int i = 0; i < ns; i++) begin
      txd = !(bad_stop && i == 0);
      repeat (BIT_CLKS) @(negedge clk);
    end
    txd = 1'b1;
  endtask

  // short low pulse that the receiver must reject as a false start
  task automatic glitch(input int n);
    txd = 1'b0;
    repeat (n) @(negedge clk);
    txd = 1'b1;
  endtask

endmodule // urxfs_tx_model

// *** hw/urxfs_baud.sv ***
// bit-rate divider: source ticks divided by n plus one
module urxfs_baud (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // source and divisor
  input  wire logic       src_tick,
  input  wire logic [7:0] brg_n,
  // sixteen-times bit rate enable
  output logic            tick16
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } urxfs_baud_type;

  urxfs_baud_type s_r;
  urxfs_baud_type s_nxt;

  // ==========================================================
  // divider
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (src_tick) begin
      if (s_r.cnt == 8'h00) begin
        s_nxt.cnt  = brg_n; // [R22]
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick16 = s_r.tick;

  chk_div_period: assert property (@(posedge clk) disable iff (rst) // [R22]
    (src_tick && s_r.cnt == 8'h00) |=> (tick16 && s_r.cnt == $past(brg_n)))
    else $error("divider did not reload on terminal count");

endmodule // urxfs_baud

// *** hw/urxfs_pkg.sv ***
// package: constants, types and states of the uart receiver block
// Function
// R1: pin roles follow flow enable, separate select and function select inputs.
// R2: separated flow pins take the clock pin, so external clock is unusable.
// R3: host sets the port direction of a clear-to-send pin to input.
// R4: frames are accepted only while the receive enable flag is set.
// R5: the 1/16 receive divider restarts at the start bit, then data shifts in.
// R6: request-to-send is high while receive disabled, low once enabled.
// R7: request-to-send returns high as soon as a reception begins.
// R8: after the last bit the frame goes to the buffer, complete flag set.
// R9: reading the buffer low byte drives request-to-send low again.
// R10: overrun sets when a frame lands while the complete flag is set.
// R11: framing error sets when a stop bit is found low.
// R12: parity error sets when received parity mismatches odd or even setting.
// R13: summary error is set whenever overrun, framing or parity error is set.
// R14: complete, overrun, framing and parity flags update at the buffer transfer.
// R15: framing, parity, summary clear on buffer read or receive disable; the code keeps summary set on a buffer read while overrun is set.
// R16: overrun clears only when receive enable is zero, never on reads.
// R17: a receive interrupt request is raised when a frame completes.
// R18: interrupt mode 0 requests every reception, 1 only erroneous ones.
// R19: sleep mode is active while the sleep select input is set.
// R20: in sleep, frames with top data bit 0 are dropped without effects.
// R21: master sends address frames with top bit 1, data with top bit 0.
// R22: receive clock is source divided by bit rate value plus one, then 16.
// R23: frames carry 7, 8 or 9 data bits, otherwise identical.
// R24: start bit rechecked at its middle; later bits sampled at their centre.
package urxfs_pkg;

  // ==========================================================
  // frame timing in 16x ticks
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [3:0] BIT_LAST  = 4'hf;

  // ==========================================================
  // data length codes
  localparam logic [1:0] LEN_7 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_9 = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [8:0] BUF_RESET = 9'h000;
  localparam logic [7:0] BRG_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } urxfs_state_type;

  typedef struct packed {
    logic [1:0] data_len;
    logic       parity_en;
    logic       parity_odd;
    logic       two_stop;
    logic       sleep_sel;
    logic       rts_sel;
    logic       int_mode;
    logic       ext_clk_sel;
    logic [7:0] brg_n;
  } urxfs_cfg_type;

  typedef struct packed {
    logic flow_disable;
    logic separate;
    logic func_sel;
  } urxfs_flow_type;

  typedef struct packed {
    logic rx_complete_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic summary_error_flag;
  } urxfs_flags_type;

endpackage

// *** hw/urxfs_rx.sv ***
// uart receiver with flow control pins and multiprocessor sleep
module urxfs_rx (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // host control
  input  wire logic                     rx_enable_flag,
  input  wire urxfs_pkg::urxfs_cfg_type  cfg,
  input  wire urxfs_pkg::urxfs_flow_type flow,
  input  wire logic                     int_src_tick,
  input  wire logic                     buf_lo_read,
  // host status
  output logic [8:0]                    rx_buffer,
  output urxfs_pkg::urxfs_flags_type     flags,
  output logic                          rx_irq,
  output logic                          clear_to_send_in,
  // serial pins
  input  wire logic                     rxd,
  input  wire logic                     flow_pin_in,
  output logic                          flow_pin_out,
  output logic                          flow_pin_oe,
  input  wire logic                     serial_clock_pin,
  output logic                          serial_clock_oe
);

  typedef struct packed {
    urxfs_pkg::urxfs_state_type st;
    logic                       rxd_s1;
    logic                       rxd_s2;
    logic                       fp_s1;
    logic                       fp_s2;
    logic                       ck_s1;
    logic                       ck_s2;
    logic                       ck_prev;
    logic                       re_prev;
    logic [3:0]                 tick_cnt;
    logic [3:0]                 bit_idx;
    logic                       stop_idx;
    logic [8:0]                 shreg;
    logic                       par_acc;
    logic                       par_bad;
    logic                       fer_acc;
    logic [8:0]                 rbuf;
    urxfs_pkg::urxfs_flags_type  flg;
    logic                       rts;
    logic                       irq;
    logic                       cts;
    logic                       fp_oe;
    logic                       ck_oe;
  } urxfs_rx_state_type;

  urxfs_rx_state_type s_r;
  urxfs_rx_state_type s_nxt;

  logic tick16;
  logic src_tick;
  logic xfer;
  logic drop;

  // ==========================================================
  // helpers
  function automatic logic [3:0] data_bits(input logic [1:0] len);
    case (len)
      urxfs_pkg::LEN_7: data_bits = 4'h7;
      urxfs_pkg::LEN_9: data_bits = 4'h9;
      default:          data_bits = 4'h8;
    endcase
  endfunction

  function automatic logic top_bit(input logic [8:0] d,
                                   input logic [1:0] len);
    case (len)
      urxfs_pkg::LEN_7: top_bit = d[6];
      urxfs_pkg::LEN_9: top_bit = d[8];
      default:          top_bit = d[7];
    endcase
  endfunction

  // ==========================================================
  // clock source
  // separated flow pins steal the clock pin, so internal is forced
  assign src_tick = (cfg.ext_clk_sel && !(flow.separate && !flow.flow_disable))
                    ? (s_r.ck_s2 && !s_r.ck_prev) : int_src_tick; // [R2]

  urxfs_baud u_baud (
    .clk    (clk),
    .rst    (rst),
    .src_tick (src_tick),
    .brg_n  (cfg.brg_n),
    .tick16 (tick16)
  );

  // ==========================================================
  // receive state machine and flags
  always_comb begin
    s_nxt         = s_r;
    xfer          = 1'b0;
    drop          = 1'b0;
    s_nxt.irq     = 1'b0;
    s_nxt.rxd_s1  = rxd;
    s_nxt.rxd_s2  = s_r.rxd_s1;
    s_nxt.fp_s1   = flow_pin_in;
    s_nxt.fp_s2   = s_r.fp_s1;
    s_nxt.ck_s1   = serial_clock_pin;
    s_nxt.ck_s2   = s_r.ck_s1;
    s_nxt.ck_prev = s_r.ck_s2;
    s_nxt.re_prev = rx_enable_flag;

    if (tick16) begin
      s_nxt.tick_cnt = s_r.tick_cnt + 4'h1;
    end

    case (s_r.st)
      urxfs_pkg::ST_IDLE: begin
        if (rx_enable_flag && !s_r.rxd_s2) begin // [R4]
          s_nxt.st       = urxfs_pkg::ST_START;
          s_nxt.tick_cnt = 4'h0; // [R5]
        end
      end
      urxfs_pkg::ST_START: begin
        if (tick16 && s_r.tick_cnt == urxfs_pkg::START_MID) begin
          if (s_r.rxd_s2) begin
            s_nxt.st = urxfs_pkg::ST_IDLE; // [R24]
          end else begin
            s_nxt.st       = urxfs_pkg::ST_DATA;
            s_nxt.tick_cnt = 4'h0;
            s_nxt.bit_idx  = 4'h0;
            s_nxt.shreg    = 9'h000;
            s_nxt.par_acc  = 1'b0;
            s_nxt.fer_acc  = 1'b0;
            s_nxt.par_bad  = 1'b0;
            s_nxt.stop_idx = 1'b0;
          end
        end
      end
      urxfs_pkg::ST_DATA: begin
        if (tick16 && s_r.tick_cnt == urxfs_pkg::BIT_LAST) begin // [R24]
          s_nxt.shreg[s_r.bit_idx] = s_r.rxd_s2; // [R5] [R23]
          s_nxt.par_acc = s_r.par_acc ^ s_r.rxd_s2;
          s_nxt.bit_idx = s_r.bit_idx + 4'h1;
          if (s_r.bit_idx == data_bits(cfg.data_len) - 4'h1) begin
            s_nxt.st = cfg.parity_en ? urxfs_pkg::ST_PAR
                                     : urxfs_pkg::ST_STOP;
          end
        end
      end
      urxfs_pkg::ST_PAR: begin
        if (tick16 && s_r.tick_cnt == urxfs_pkg::BIT_LAST) begin
          // total ones must be odd in odd mode, even in even mode
          s_nxt.par_bad = (s_r.par_acc ^ s_r.rxd_s2) != cfg.parity_odd; // [R12]
          s_nxt.st      = urxfs_pkg::ST_STOP;
        end
      end
      urxfs_pkg::ST_STOP: begin
        if (tick16 && s_r.tick_cnt == urxfs_pkg::BIT_LAST) begin
          s_nxt.fer_acc  = s_r.fer_acc | !s_r.rxd_s2; // [R11]
          s_nxt.stop_idx = 1'b1;
          if (!cfg.two_stop || s_r.stop_idx) begin
            s_nxt.st = urxfs_pkg::ST_IDLE;
            if (cfg.sleep_sel && !top_bit(s_r.shreg, cfg.data_len)) begin
              drop = 1'b1; // [R19] [R20]
            end else begin
              xfer = 1'b1; // [R8]
            end
          end
        end
      end
      default: begin
        s_nxt.st = urxfs_pkg::ST_IDLE;
      end
    endcase

    // a disabled receiver abandons any frame in progress
    if (!rx_enable_flag) begin
      s_nxt.st = urxfs_pkg::ST_IDLE; // [R4]
      xfer     = 1'b0;
      drop     = 1'b0;
    end

    // clears first, so a same-cycle transfer wins
    if (buf_lo_read || !rx_enable_flag) begin
      s_nxt.flg.framing_error_flag = 1'b0; // [R15]
      s_nxt.flg.parity_error_flag  = 1'b0; // [R15]
    end
    if (buf_lo_read) begin
      s_nxt.flg.rx_complete_flag = 1'b0;
    end
    if (!rx_enable_flag) begin
      s_nxt.flg.overrun_error_flag = 1'b0; // [R16]
    end

    if (xfer) begin
      s_nxt.rbuf                 = s_r.shreg; // [R8]
      s_nxt.flg.rx_complete_flag = 1'b1; // [R14]
      if (s_r.flg.rx_complete_flag) begin
        s_nxt.flg.overrun_error_flag = 1'b1; // [R10] [R14]
      end
      if (s_nxt.fer_acc) begin
        s_nxt.flg.framing_error_flag = 1'b1; // [R11] [R14]
      end
      if (cfg.parity_en && s_r.par_bad) begin
        s_nxt.flg.parity_error_flag = 1'b1; // [R12] [R14]
      end
      s_nxt.irq = !cfg.int_mode || s_r.flg.rx_complete_flag
                  || s_nxt.fer_acc
                  || (cfg.parity_en && s_r.par_bad); // [R17] [R18]
    end

    s_nxt.flg.summary_error_flag = s_nxt.flg.overrun_error_flag
                                   | s_nxt.flg.framing_error_flag
                                   | s_nxt.flg.parity_error_flag; // [R13]

    // request-to-send: high when disabled or once a start bit is seen, low on enable or on a buffer read while idle
    if (!rx_enable_flag) begin
      s_nxt.rts = 1'b1; // [R6]
    end else if (s_r.st == urxfs_pkg::ST_IDLE
                 && s_nxt.st == urxfs_pkg::ST_START) begin
      s_nxt.rts = 1'b1; // [R7]
    end else if (!s_r.re_prev) begin
      s_nxt.rts = 1'b0; // [R6]
    end else if (buf_lo_read && s_r.st == urxfs_pkg::ST_IDLE) begin
      s_nxt.rts = 1'b0; // [R9]
    end

    // pin roles
    s_nxt.fp_oe = !flow.flow_disable && (flow.separate || flow.func_sel)
                  && cfg.rts_sel; // [R1]
    s_nxt.ck_oe = 1'b0; // [R1]
    if (flow.flow_disable) begin
      s_nxt.cts = 1'b0; // [R1]
    end else if (flow.separate) begin
      s_nxt.cts = s_r.ck_s2; // [R1] [R2]
    end else if (!flow.func_sel) begin
      s_nxt.cts = s_r.fp_s2; // [R1] [R3]
    end else begin
      s_nxt.cts = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r      <= '0;
      s_r.st   <= urxfs_pkg::ST_IDLE;
      s_r.rbuf <= urxfs_pkg::BUF_RESET;
      s_r.rts  <= 1'b1;
      s_r.rxd_s1 <= 1'b1;
      s_r.rxd_s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rx_buffer        = s_r.rbuf;
  assign flags            = s_r.flg;
  assign rx_irq           = s_r.irq;
  assign clear_to_send_in = s_r.cts;
  assign flow_pin_out     = s_r.rts;
  assign flow_pin_oe      = s_r.fp_oe;
  assign serial_clock_oe  = s_r.ck_oe;

  // ==========================================================
  // checks
  chk_rx_gate_idle: assert property (@(posedge clk) disable iff (rst) // [R4]
    !rx_enable_flag |=> s_r.st == urxfs_pkg::ST_IDLE)
    else $error("receiver active while disabled");

  chk_rts_disabled_high: assert property (@(posedge clk) // [R6]
    disable iff (rst) !rx_enable_flag |=> s_r.rts)
    else $error("request-to-send low while disabled");

  chk_rts_start_high: assert property (@(posedge clk) disable iff (rst) // [R7]
    (s_r.st == urxfs_pkg::ST_IDLE && s_nxt.st == urxfs_pkg::ST_START)
    |=> s_r.rts ##1 (s_r.rts || !rx_enable_flag || buf_lo_read))
    else $error("request-to-send not raised at start");

  chk_rts_read_low: assert property (@(posedge clk) disable iff (rst) // [R9]
    (buf_lo_read && rx_enable_flag && s_r.re_prev
     && s_r.st == urxfs_pkg::ST_IDLE && s_nxt.st == urxfs_pkg::ST_IDLE)
    |=> !s_r.rts)
    else $error("request-to-send not lowered after buffer read");

  chk_start_mid_reject: assert property (@(posedge clk) // [R24]
    disable iff (rst)
    (s_r.st == urxfs_pkg::ST_START && tick16 && rx_enable_flag
     && s_r.tick_cnt == 4'h7 && s_r.rxd_s2) |=> s_r.st == urxfs_pkg::ST_IDLE)
    else $error("false start bit not rejected");

  chk_xfer_buffer: assert property (@(posedge clk) disable iff (rst) // [R8]
    xfer |=> (s_r.flg.rx_complete_flag && s_r.rbuf == $past(s_r.shreg)))
    else $error("frame not moved to buffer");

  chk_overrun_set: assert property (@(posedge clk) disable iff (rst) // [R10]
    (xfer && s_r.flg.rx_complete_flag) |=> s_r.flg.overrun_error_flag)
    else $error("overrun not flagged");

  chk_overrun_sticky: assert property (@(posedge clk) // [R16]
    disable iff (rst) (s_r.flg.overrun_error_flag && rx_enable_flag)
    |=> s_r.flg.overrun_error_flag)
    else $error("overrun cleared while enabled");

  chk_err_clear: assert property (@(posedge clk) disable iff (rst) // [R15]
    (!rx_enable_flag || (buf_lo_read && !xfer))
    |=> !s_r.flg.framing_error_flag && !s_r.flg.parity_error_flag)
    else $error("error flags not cleared");

  chk_summary_or: assert property (@(posedge clk) disable iff (rst) // [R13]
    s_r.flg.summary_error_flag == (s_r.flg.overrun_error_flag
      | s_r.flg.framing_error_flag | s_r.flg.parity_error_flag))
    else $error("summary flag does not match error flags");

  chk_sleep_drop: assert property (@(posedge clk) disable iff (rst) // [R20]
    (drop && !buf_lo_read && rx_enable_flag)
    |=> ($stable(s_r.rbuf) && $stable(s_r.flg) && !rx_irq))
    else $error("sleep frame changed buffer or flags");

  chk_irq_mode: assert property (@(posedge clk) disable iff (rst) // [R18]
    rx_irq |-> ($past(xfer) && (!$past(cfg.int_mode)
      || s_r.flg.summary_error_flag)))
    else $error("interrupt raised without qualifying reception");

  cov_frame_done: cover property (@(posedge clk) disable iff (rst) xfer);
  cov_overrun: cover property (@(posedge clk) disable iff (rst)
    xfer && s_r.flg.rx_complete_flag);
  cov_sleep_drop: cover property (@(posedge clk) disable iff (rst) drop);
  cov_irq_err: cover property (@(posedge clk) disable iff (rst)
    rx_irq && cfg.int_mode);

endmodule // urxfs_rx
